// file: verilog/pulse_dist_pkg.sv
// constants, carrier types and sequencer states for the pulse distributor controller
package pulse_dist_pkg;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 4;
   localparam int CHOICE_NS     = 500;
   localparam int ADDR_SLOT_NS  = 1250;
   localparam int EXEC_NS       = 500;
   localparam int VERIFY_WIN_NS = 3000;
   localparam logic [9:0] CHOICE_CYC = 10'((CHOICE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [9:0] ADDR_CYC   = 10'((ADDR_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [9:0] EXEC_CYC   = 10'((EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [9:0] WAIT_CYC   = 10'(VERIFY_WIN_NS / CLK_PERIOD_NS);

   // ************************************************************
   // enable register, operand and maintenance field positions
   // ************************************************************
   localparam int PU_HEALTH_INH_BIT = 5;
   localparam int REPLY_INH_BIT     = 6;
   localparam int MODE_LSB          = 7;
   localparam int Z_LOW_BIT         = 9;
   localparam int EXEC_LSB          = 10;
   localparam int X_LSB             = 14;
   localparam int Y_LSB             = 17;
   localparam int Z_LSB             = 20;
   localparam int SHORT_PARITY_BIT  = 23;
   localparam int TEST_BIT          = 32;
   localparam int RESET_BIT         = 33;
   localparam int MAINT_HEALTH_BIT  = 4;
   localparam logic [2:0] MODE_LONG  = 3'h0;
   localparam logic [2:0] MODE_SHORT = 3'h1;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic [7:0]  x;
      logic [7:0]  y;
      logic [15:0] z;
   } enable_addr_t;

   typedef struct packed {
      logic [7:0] x;
      logic [7:0] y;
      logic [7:0] z;
   } verify_addr_t;

   typedef struct packed {
      logic pu_health;
      logic parity_mismatch;
      logic dist_health;
      logic reply_match;
      logic exec_return;
   } error_summary_t;

   typedef enum logic [5:0] {
      st_idle   = 6'h01,
      st_choice = 6'h02,
      st_addr   = 6'h04,
      st_exec   = 6'h08,
      st_wait   = 6'h10,
      st_check  = 6'h20
   } seq_state_t;

endpackage

// file: verilog/enable_translate.sv
// enable address and execute translator: binary fields to one-hot codes
`timescale 1ns/1ps
`default_nettype none
module enable_translate (
   input  wire logic [22:0]                 enable_i,
   output wire pulse_dist_pkg::enable_addr_t addr_o,
   output wire logic [15:0]                 exec_sel_o
);
   wire logic [7:0]  x_hot;
   wire logic [7:0]  y_hot;
   wire logic [15:0] z_hot;
   wire logic [3:0]  z_bin;

   // top z bit (enable bit 22) picks the half, so it also sets bipolar polarity
   assign z_bin = {enable_i[pulse_dist_pkg::Z_LSB+2:pulse_dist_pkg::Z_LSB],
                   enable_i[pulse_dist_pkg::Z_LOW_BIT]};

   genvar i;
   generate
      for (i = 0; i < 16; i++) begin : g_line
         assign exec_sel_o[i] = (enable_i[pulse_dist_pkg::EXEC_LSB+3:pulse_dist_pkg::EXEC_LSB]
                                 == 4'(i));
         assign z_hot[i] = (z_bin == 4'(i));
         if (i < 8) begin : g_xy
            assign x_hot[i] = (enable_i[pulse_dist_pkg::X_LSB+2:pulse_dist_pkg::X_LSB] == 3'(i));
            assign y_hot[i] = (enable_i[pulse_dist_pkg::Y_LSB+2:pulse_dist_pkg::Y_LSB] == 3'(i));
         end
      end
   endgenerate

   assign addr_o = {x_hot, y_hot, z_hot};
endmodule
`default_nettype wire

// file: verilog/pu_write_translate.sv
// peripheral write data translation chosen by the mode field
`timescale 1ns/1ps
`default_nettype none
module pu_write_translate (
   input  wire logic [2:0]  mode_i,
   input  wire logic [35:0] operand_i,
   output logic      [35:0] wdata_o
);
   always_comb begin
      unique case (mode_i)
         // long passes all, short adds odd parity
         pulse_dist_pkg::MODE_LONG:  wdata_o = operand_i;
         pulse_dist_pkg::MODE_SHORT: wdata_o = {12'h000, ~^operand_i[22:0], operand_i[22:0]};
         default:                    wdata_o = {13'h0000, operand_i[22:0]};
      endcase
   end
endmodule
`default_nettype wire

// file: verilog/pulse_dist_ctrl.sv
// central controller sequencer that drives a pulse distributor and checks its answers
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - bits 10-13 of enable register decode to a one-hot execute line.
// - echo must match execute selection, otherwise flag execute return failure.
// - long mode passes bits 0-35; short passes 0-22 plus parity bit 23.
// - enable bits 7-9 choose which peripheral write data translation applies.
// - verify reply mismatch flags reply match failure unless enable bit 6 set.
// - five maintenance bits are captured into diagnostic echo bits 16-20.
// - missing distributor health signal flags distributor health error.
// - duplexed controllers cross-compare odd reply parity; mismatch sets a flag.
// - missing peripheral health signal flags error unless enable bit 5 set.
// - any error summary bit raises fault source; interrupt only when unmasked.
// - operand bits 32 and 33 drive distributor test and reset leads.
// - peripheral returns verify roughly 1.5 or 2.5 microseconds after enable.
module pulse_dist_ctrl (
   input  wire logic                           clock_i,
   input  wire logic                           reset_i,
   input  wire logic                           start_i,
   input  wire logic                           bus_sel_i,
   input  wire logic [22:0]                    enable_reg_i,
   input  wire logic [35:0]                    operand_i,
   input  wire logic                           duplex_i,
   input  wire logic                           mask_i,
   input  wire logic [4:0]                     clear_i,
   output logic                                busy_o,
   output logic                                done_o,
   output pulse_dist_pkg::error_summary_t      summary_o,
   output logic                                irq_source_o,
   output logic                                irq_o,
   output logic [21:0]                         diag_echo_o,
   output pulse_dist_pkg::verify_addr_t        verify_o,
   output logic                                bus_choice_o,
   output logic                                bus_select_o,
   output pulse_dist_pkg::enable_addr_t        addr_o,
   output logic [15:0]                         execute_o,
   output logic                                test_o,
   output logic                                reset_lead_o,
   input  wire logic [15:0]                    echo_i,
   input  wire pulse_dist_pkg::verify_addr_t   verify_i,
   input  wire logic [4:0]                     maint_i,
   output logic [35:0]                         pu_wdata_o,
   input  wire logic                           pu_health_i,
   input  wire logic [35:0]                    pu_reply_i,
   input  wire logic                           mate_parity_i,
   output logic                                own_parity_o
);

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [82:0] pin_meta;
   logic [82:0] pin_sync;
   logic [15:0] echo_s;
   logic [23:0] verify_s;
   logic [4:0]  maint_s;
   logic        pu_health_s;
   logic [35:0] reply_s;
   logic        mate_s;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= {mate_parity_i, pu_reply_i, pu_health_i, maint_i, verify_i, echo_i};
         pin_sync <= pin_meta;
      end
   end

   assign echo_s      = pin_sync[15:0];
   assign verify_s    = pin_sync[39:16];
   assign maint_s     = pin_sync[44:40];
   assign pu_health_s = pin_sync[45];
   assign reply_s     = pin_sync[81:46];
   assign mate_s      = pin_sync[82];

   // ************************************************************
   // translators
   // ************************************************************
   logic [22:0]                  ena;
   logic [35:0]                  opnd;
   pulse_dist_pkg::enable_addr_t xlat_addr;
   logic [15:0]                  exec_sel;
   logic [35:0]                  xlat_wdata;

   enable_translate u_enable_translate (
      .enable_i   (ena),
      .addr_o     (xlat_addr),
      .exec_sel_o (exec_sel)
   );

   pu_write_translate u_pu_write_translate (
      .mode_i    (ena[pulse_dist_pkg::MODE_LSB+2:pulse_dist_pkg::MODE_LSB]),
      .operand_i (opnd),
      .wdata_o   (xlat_wdata)
   );

   // ************************************************************
   // sequencer
   // ************************************************************
   pulse_dist_pkg::seq_state_t   state;
   pulse_dist_pkg::seq_state_t   next_state;
   logic [9:0]                   cnt;
   logic [9:0]                   next_cnt;
   logic [22:0]                  next_ena;
   logic [35:0]                  next_opnd;
   logic                         bus;
   logic                         next_bus;
   logic [15:0]                  echo_cap;
   logic [15:0]                  next_echo_cap;
   logic [4:0]                   maint_cap;
   logic [4:0]                   next_maint_cap;
   logic                         pu_ok;
   logic                         next_pu_ok;
   logic [23:0]                  verify_cap;
   logic [23:0]                  next_verify_cap;
   logic                         in_window;

   assign in_window = (state == pulse_dist_pkg::st_exec) || (state == pulse_dist_pkg::st_wait);

   always_comb begin
      next_state      = state;
      next_cnt        = cnt;
      next_ena        = ena;
      next_opnd       = opnd;
      next_bus        = bus;
      next_echo_cap   = echo_cap;
      next_maint_cap  = maint_cap;
      next_pu_ok      = pu_ok;
      next_verify_cap = verify_cap;
      // answers may come any time from execute to the end of the verify window
      if (in_window) begin
         next_echo_cap  = echo_cap | echo_s;
         next_maint_cap = maint_cap | maint_s;
         next_pu_ok     = pu_ok | pu_health_s;
         if (verify_cap == 24'h000000) begin
            next_verify_cap = verify_s;
         end
      end
      unique case (state)
         pulse_dist_pkg::st_idle: begin
            if (start_i) begin
               next_ena        = enable_reg_i;
               next_opnd       = operand_i;
               next_bus        = bus_sel_i;
               next_echo_cap   = 16'h0000;
               next_maint_cap  = 5'h00;
               next_pu_ok      = 1'b0;
               next_verify_cap = 24'h000000;
               next_cnt        = pulse_dist_pkg::CHOICE_CYC - 10'h001;
               next_state      = pulse_dist_pkg::st_choice;
            end
         end
         pulse_dist_pkg::st_choice: begin
            if (cnt == 10'h000) begin
               next_cnt   = pulse_dist_pkg::ADDR_CYC - 10'h001;
               next_state = pulse_dist_pkg::st_addr;
            end else begin
               next_cnt = cnt - 10'h001;
            end
         end
         pulse_dist_pkg::st_addr: begin
            if (cnt == 10'h000) begin
               next_cnt   = pulse_dist_pkg::EXEC_CYC - 10'h001;
               next_state = pulse_dist_pkg::st_exec;
            end else begin
               next_cnt = cnt - 10'h001;
            end
         end
         pulse_dist_pkg::st_exec: begin
            if (cnt == 10'h000) begin
               next_cnt   = pulse_dist_pkg::WAIT_CYC - 10'h001;
               next_state = pulse_dist_pkg::st_wait;
            end else begin
               next_cnt = cnt - 10'h001;
            end
         end
         pulse_dist_pkg::st_wait: begin
            if (cnt == 10'h000) begin
               next_state = pulse_dist_pkg::st_check;
            end else begin
               next_cnt = cnt - 10'h001;
            end
         end
         pulse_dist_pkg::st_check: begin
            next_state = pulse_dist_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state        <= pulse_dist_pkg::st_idle;
         cnt          <= 10'h000;
         ena          <= 23'h000000;
         opnd         <= 36'h000000000;
         bus          <= 1'b0;
         echo_cap     <= 16'h0000;
         maint_cap    <= 5'h00;
         pu_ok        <= 1'b0;
         verify_cap   <= 24'h000000;
         busy_o       <= 1'b0;
         done_o       <= 1'b0;
         bus_choice_o <= 1'b0;
         bus_select_o <= 1'b0;
         addr_o       <= '0;
         execute_o    <= 16'h0000;
         test_o       <= 1'b0;
         reset_lead_o <= 1'b0;
         pu_wdata_o   <= 36'h000000000;
         own_parity_o <= 1'b0;
         diag_echo_o  <= 22'h000000;
         verify_o     <= '0;
      end else begin
         state        <= next_state;
         cnt          <= next_cnt;
         ena          <= next_ena;
         opnd         <= next_opnd;
         bus          <= next_bus;
         echo_cap     <= next_echo_cap;
         maint_cap    <= next_maint_cap;
         pu_ok        <= next_pu_ok;
         verify_cap   <= next_verify_cap;
         busy_o       <= (next_state != pulse_dist_pkg::st_idle);
         done_o       <= (state == pulse_dist_pkg::st_check);
         bus_choice_o <= (next_state == pulse_dist_pkg::st_choice);
         // the same bus carries the whole order
         bus_select_o <= next_bus;
         // address lines idle at zero so the distributor sees no stale code
         addr_o       <= (next_state == pulse_dist_pkg::st_addr) ? xlat_addr : '0;
         // execute on the selected private line
         execute_o    <= (next_state == pulse_dist_pkg::st_exec) ? exec_sel : 16'h0000;
         // test and reset leads from the operand
         test_o       <= next_opnd[pulse_dist_pkg::TEST_BIT];
         reset_lead_o <= next_opnd[pulse_dist_pkg::RESET_BIT];
         pu_wdata_o   <= xlat_wdata;
         own_parity_o <= ~^reply_s;
         diag_echo_o  <= {next_bus, next_maint_cap, next_echo_cap};
         verify_o     <= next_verify_cap;
      end
   end

   // ************************************************************
   // error summary and interrupt source
   // ************************************************************
   pulse_dist_pkg::error_summary_t err_set;
   pulse_dist_pkg::error_summary_t next_summary;
   logic                           next_irq_source;
   logic                           next_irq;
   logic                           checking;

   assign checking = (state == pulse_dist_pkg::st_check);

   always_comb begin
      err_set = '0;
      if (checking) begin
         // echo must equal the execute selection
         err_set.exec_return     = (echo_cap != exec_sel);
         // only unipolar outputs answer with a verify
         err_set.reply_match     = !ena[pulse_dist_pkg::REPLY_INH_BIT] && (|xlat_addr.z[7:0])
                                   && (verify_cap != {xlat_addr.x, xlat_addr.y, xlat_addr.z[7:0]});
         err_set.dist_health     = !maint_cap[pulse_dist_pkg::MAINT_HEALTH_BIT];
         err_set.parity_mismatch = duplex_i && (mate_s != ~^reply_s);
         err_set.pu_health       = !ena[pulse_dist_pkg::PU_HEALTH_INH_BIT] && !pu_ok;
      end
      // a new error wins over a clear in the same cycle
      next_summary    = (summary_o & ~clear_i) | err_set;
      next_irq_source = |next_summary;
      next_irq        = next_irq_source && !mask_i;
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         summary_o    <= '0;
         irq_source_o <= 1'b0;
         irq_o        <= 1'b0;
      end else begin
         summary_o    <= next_summary;
         irq_source_o <= next_irq_source;
         irq_o        <= next_irq;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);

   sequence s_choice_end;
      $fell(bus_choice_o);
   endsequence

   sequence s_exec_start;
      $rose(|execute_o);
   endsequence

   chk_exec_onehot: assert property ((|execute_o) |-> (execute_o == exec_sel) && $onehot(execute_o))
      else $error("execute line not the decoded one");
   chk_echo_match: assert property (checking && (echo_cap != exec_sel) |=> summary_o.exec_return)
      else $error("missing echo not flagged");
   chk_short_parity: assert property ((ena[9:7] == pulse_dist_pkg::MODE_SHORT) && $stable(opnd)
      && $stable(ena) |-> (^pu_wdata_o[23:0]) && (pu_wdata_o[22:0] == opnd[22:0]))
      else $error("short binary word wrong");
   chk_mode_other: assert property ((ena[9:8] != 2'h0) && $stable(opnd) && $stable(ena)
      |-> pu_wdata_o[35:23] == 13'h0000)
      else $error("coded translation upper bits set");
   chk_reply_inhibit: assert property (checking && ena[6] && !summary_o.reply_match
      |=> !summary_o.reply_match)
      else $error("reply check not inhibited");
   chk_diag_capture: assert property (checking |-> diag_echo_o[20:16] == maint_cap)
      else $error("maintenance bits not captured");
   chk_dist_health: assert property (checking && !maint_cap[4] |=> summary_o.dist_health)
      else $error("distributor health error not flagged");
   chk_parity_cross: assert property (checking && duplex_i && (mate_s == own_parity_o)
      && $stable(reply_s) && !summary_o.parity_mismatch |=> !summary_o.parity_mismatch)
      else $error("parity mismatch flagged on match");
   chk_pu_health: assert property (checking && !ena[5] && !pu_ok |=> summary_o.pu_health)
      else $error("peripheral health error not flagged");
   chk_irq_gate: assert property (##1 (irq_source_o == (|summary_o))
      && (irq_o == (irq_source_o && !$past(mask_i))))
      else $error("fault source or interrupt gating wrong");
   chk_test_leads: assert property ((state != pulse_dist_pkg::st_idle) |-> (test_o == opnd[32])
      && (reset_lead_o == opnd[33]))
      else $error("test or reset lead wrong");
   chk_order_timing: assert property (s_choice_end |-> ##[313:313] s_exec_start)
      else $error("execute not one address slot after bus choice");

endmodule
`default_nettype wire

// file: bench/pulse_dist_model.sv
// behavioural pulse distributor and peripheral unit controller facing the controller
`timescale 1ns/1ps
`default_nettype none
module pulse_dist_model (
   input  wire logic                         clock_i,
   input  wire logic                         reset_i,
   input  wire pulse_dist_pkg::enable_addr_t addr_i,
   input  wire logic [15:0]                  execute_i,
   input  wire logic [3:0]                   fault_i,
   input  wire logic                         slow_i,
   input  wire logic                         choice_i,
   input  wire logic                         bus_i,
   output logic [15:0]                       echo_o,
   output pulse_dist_pkg::verify_addr_t      verify_o,
   output logic [4:0]                        maint_o,
   output logic                              pu_health_o
);
   pulse_dist_pkg::enable_addr_t held;
   int                           t;
   logic [2:0]                   bad;
   logic                         win;
   logic                         bus_held;
   logic                         same_bus;
   always @(posedge clock_i) begin
      if (reset_i) begin
         held <= '0;
         bus_held <= 1'b0;
         t <= -1;
      end else begin
         // bus flag set by the bus choice pulse
         if (choice_i) bus_held <= bus_i;
         if (addr_i != '0) held <= addr_i;
         if (execute_i != '0 && t < 0) t <= 0;
         else if (t >= 0) t <= (t < 1000) ? t + 1 : -1;
      end
   end
   assign bad = {!$onehot(held.z), !$onehot(held.y), !$onehot(held.x)};
   assign win = same_bus && t >= (slow_i ? 625 : 375) && t < (slow_i ? 750 : 500);
   // answers stay on the bus the order came in on
   assign same_bus = (bus_i == bus_held);
   assign echo_o = (same_bus && execute_i != '0 && bad == '0 && !fault_i[0]) ? execute_i : '0;
   assign maint_o = (same_bus && execute_i != '0) ? {bad == '0 && !fault_i[1], 1'b0, bad} : '0;
   assign verify_o = (win && bad == '0 && held.z[15:8] == '0) ?
      {fault_i[2] ? {held.x[6:0], held.x[7]} : held.x, held.y, held.z[7:0]} : '0;
   assign pu_health_o = win && !fault_i[3];
endmodule
`default_nettype wire

// file: bench/pulse_dist_ctrl_tb.sv
// self-checking bench for the pulse distributor controller
`timescale 1ns/1ps
`default_nettype none
module pulse_dist_ctrl_tb;
   logic                           clock_i, reset_i, start_i, bus_sel_i, duplex_i, mask_i, slow;
   logic                           mate_parity_i, pu_health_i, busy_o, done_o, irq_source_o;
   logic                           irq_o, bus_choice_o, bus_select_o, test_o, reset_lead_o;
   logic                           own_parity_o;
   logic [22:0]                    enable_reg_i;
   logic [35:0]                    operand_i, pu_reply_i, pu_wdata_o;
   logic [4:0]                     clear_i, maint_i;
   logic [3:0]                     fault;
   logic [21:0]                    diag_echo_o;
   logic [15:0]                    execute_o, echo_i;
   pulse_dist_pkg::error_summary_t summary_o;
   pulse_dist_pkg::verify_addr_t   verify_o, verify_i;
   pulse_dist_pkg::enable_addr_t   addr_o;
   logic [31:0]                    seed = 32'h403D96D5;
   int                             num_errors = 0, compares = 0;
   pulse_dist_ctrl u_pulse_dist_ctrl (
      .clock_i, .reset_i, .start_i, .bus_sel_i, .enable_reg_i, .operand_i, .duplex_i, .mask_i,
      .clear_i, .busy_o, .done_o, .summary_o, .irq_source_o, .irq_o, .diag_echo_o, .verify_o,
      .bus_choice_o, .bus_select_o, .addr_o, .execute_o, .test_o, .reset_lead_o, .echo_i,
      .verify_i, .maint_i, .pu_wdata_o, .pu_health_i, .pu_reply_i, .mate_parity_i, .own_parity_o
   );
   pulse_dist_model u_pulse_dist_model (
      .clock_i, .reset_i, .addr_i(addr_o), .execute_i(execute_o), .fault_i(fault), .slow_i(slow),
      .choice_i(bus_choice_o), .bus_i(bus_select_o),
      .echo_o(echo_i), .verify_o(verify_i), .maint_o(maint_i), .pu_health_o(pu_health_i)
   );
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task check(input string name, input logic [35:0] exp, input logic [35:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task stop_test;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // first eight orders walk every mode and each single fault, the rest are random
   task automatic order(input int i);
      logic [22:0] e;
      logic [35:0] p, w;
      logic [7:0]  x, y;
      logic [15:0] z, ex;
      logic [21:0] d;
      logic [23:0] v;
      logic [4:0]  s;
      logic        uni;
      int          n = 0, ta = 0, tx = 0, na = 0, ne = 0, tc;
      e = 23'(rnd());
      p = 36'({rnd(), rnd()});
      fault = 4'(i > 7 ? rnd() : (i > 3 ? 1 << (i - 4) : 0));
      if (i < 8) e = {1'b0, e[21:10], 3'(i), 2'b00, e[4:0]};
      // one order always takes a bipolar output
      if (i == 8) e[22] = 1'b1;
      tc = int'(pulse_dist_pkg::CHOICE_CYC) + int'(pulse_dist_pkg::ADDR_CYC);
      x = 8'(1) << e[16:14];
      y = 8'(1) << e[19:17];
      z = 16'(1) << {e[22:20], e[9]};
      ex = 16'(1) << e[13:10];
      uni = ~e[22];
      w = (e[9:7] == 3'h1) ? {12'h0, ~^p[22:0], p[22:0]} : {13'h0, p[22:0]};
      if (e[9:7] == 3'h0) w = p;
      s = {~e[5] & fault[3], e[2] & (e[3] != ~^p), fault[1], uni & ~e[6] & fault[2], fault[0]};
      d = {p[35], ~fault[1], 4'h0, fault[0] ? 16'h0 : ex};
      v = uni ? {fault[2] ? {x[6:0], x[7]} : x, y, z[7:0]} : 24'h0;
      start_i = 1'b1;
      clear_i = 5'h1F;
      bus_sel_i = p[35];
      enable_reg_i = e;
      operand_i = p;
      pu_reply_i = {p[3:0], p[35:4]};
      slow = e[0];
      mask_i = e[1];
      duplex_i = e[2];
      mate_parity_i = e[3];
      while (done_o !== 1'b1 && n < 2000) begin
         @(negedge clock_i);
         n++;
         clear_i = 5'h00;
         // refused start while busy, with the other bus
         start_i = (n == 700);
         bus_sel_i = (n > 699) ^ p[35];
         if (ta == 0 && addr_o != '0) ta = n;
         if (tx == 0 && execute_o != '0) tx = n;
         if (ta == n) check("address", 36'({x, y, z}), 36'(addr_o));
         if (tx == n) check("execute", 36'(ex), 36'(execute_o));
         na += int'(addr_o != '0);
         ne += int'(execute_o != '0);
         if (n == 1) check("busy choice", 36'(2'b11), 36'({busy_o, bus_choice_o}));
         if (ta == n) check("choice end", 36'(0), 36'(bus_choice_o));
      end
      check("address slot", 36'(int'(pulse_dist_pkg::CHOICE_CYC) + 1), 36'(ta));
      check("execute slot", 36'(tc + 1), 36'(tx));
      check("done", 36'(tc + int'(pulse_dist_pkg::EXEC_CYC) + int'(pulse_dist_pkg::WAIT_CYC) + 2),
            36'(n));
      check("address length", 36'(pulse_dist_pkg::ADDR_CYC), 36'(na));
      check("execute length", 36'(pulse_dist_pkg::EXEC_CYC), 36'(ne));
      check("busy end", 36'(0), 36'(busy_o));
      check("summary", 36'(s), 36'(summary_o));
      check("fault source", 36'(|s), 36'(irq_source_o));
      check("diag echo", 36'(d), 36'(diag_echo_o));
      check("verify", 36'(v), 36'(verify_o));
      check("write data", w, pu_wdata_o);
      check("leads", 36'(p[33:32]), 36'({reset_lead_o, test_o}));
      check("bus", 36'(p[35]), 36'(bus_select_o));
      check("own parity", 36'(~^p), 36'(own_parity_o));
      @(negedge clock_i);
      check("interrupt", 36'(|s & ~e[1]), 36'(irq_o));
      check("done pulse", 36'(0), 36'(done_o));
   endtask
   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end
   // watchdog sized for fourteen orders of about 1316 cycles
   initial begin
      #90000;
      num_errors++;
      stop_test;
   end
   initial begin
      reset_i = 1'b1;
      {start_i, bus_sel_i, duplex_i, mask_i, slow, mate_parity_i} = '0;
      {enable_reg_i, operand_i, pu_reply_i, clear_i, fault} = '0;
      repeat (3) @(posedge clock_i);
      @(negedge clock_i);
      reset_i = 1'b0;
      for (int i = 0; i < 14; i++) order(i);
      stop_test;
   end
endmodule
`default_nettype wire
